// ==== core/chg_pkg.sv ====
package chg_pkg;
   // Register addresses on the microcontroller map; the serial page-0
   // offset of each register is its low byte.
   localparam logic [15:0] ADDR_APP = 16'ha093;
   localparam logic [15:0] ADDR_SPC = 16'ha094;
   localparam logic [15:0] ADDR_ST1 = 16'ha095;
   localparam logic [15:0] ADDR_ST2 = 16'ha096;
   localparam logic [15:0] ADDR_EVF = 16'ha097;
   localparam logic [15:0] ADDR_EVE = 16'ha098;
   localparam logic [15:0] ADDR_RSV_LO = 16'ha099;
   localparam logic [15:0] ADDR_RSV_HI = 16'ha09f;

   // Reset values of the writable registers.
   localparam logic [7:0] RST_APP = 8'h78;
   localparam logic [7:0] RST_SPC = 8'h00;
   localparam logic [7:0] RST_EVF = 8'h00;
   localparam logic [7:0] RST_EVE = 8'h01;

   // Field positions in the application settings register.
   localparam int APP_REC_LSB = 5;
   localparam int APP_REC_MSB = 7;
   localparam int APP_GOOD_LSB = 3;
   localparam int APP_GOOD_MSB = 4;

   // Bit positions in the special control register.
   localparam int SPC_CHARGER_OFF = 0;
   localparam int SPC_RECHARGE_OFF = 1;
   localparam int SPC_THERM_OFF = 2;
   localparam int SPC_VLOOP_OFF = 3;
   localparam int SPC_CLOOP_OFF = 4;
   localparam int SPC_PRIORITY = 5;

   // Status vector layout: bits 7:0 status one, bits 15:8 status two.
   localparam int ST_WIDTH = 16;
   localparam int ST_ADAPTER = 0;
   localparam int ST_LIMITED = 7;
   localparam int ST_COMPLETE = 13;
   localparam int ST_RAIL_LOW = 14;
   localparam logic [7:0] ST2_RSV_MASK = 8'h0c;

   // Event flag positions and count.
   localparam int EVT_ADAPTER = 0;
   localparam int EVT_LIMIT = 1;
   localparam int EVT_COMPLETE = 2;
   localparam int EVT_N = 3;
   localparam int ARM_DEPTH = 3;

   // Decoded analog settings.
   localparam logic [7:0] REC_STEP_MA = 8'h19;
   localparam logic [11:0] GOOD_BASE_MV = 12'h9c4;
   localparam logic [11:0] GOOD_STEP_MV = 12'h064;
endpackage : chg_pkg

// ==== core/chg_evt_if.sv ====
`timescale 1ns/100ps
interface chg_evt_if;
   logic adapter;
   logic limited;
   logic complete;
   logic clr;
   logic [7:0] wdata;
   logic [chg_pkg::EVT_N-1:0] enables;
   logic [7:0] flags;
   logic irq;

   modport regs (output adapter, limited, complete, clr, wdata, enables,
      input flags, irq);
   modport evt (input adapter, limited, complete, clr, wdata, enables,
      output flags, irq);
endinterface : chg_evt_if

// ==== core/chg_event_flags.sv ====
`timescale 1ns/100ps
module chg_event_flags (
   input wire logic clk, // System clock.
   input wire logic nrst, // Asynchronous reset, active low.
   chg_evt_if.evt ev // Status levels in, flags and request out.
);
   logic [chg_pkg::EVT_N-1:0] prev_ff;
   logic [chg_pkg::ARM_DEPTH-1:0] arm_ff;
   logic [7:0] flags_ff;
   logic irq_ff;
   logic [chg_pkg::EVT_N-1:0] now_lvl;
   logic [chg_pkg::EVT_N-1:0] set_evt;
   logic [7:0] nxt_flags;
   logic nxt_irq;

   // Current levels; detection waits until the synchronisers have filled.
   assign now_lvl = {ev.complete, ev.limited, ev.adapter};
   assign set_evt[chg_pkg::EVT_ADAPTER] = arm_ff[chg_pkg::ARM_DEPTH-1] &
      (now_lvl[chg_pkg::EVT_ADAPTER] ^ prev_ff[chg_pkg::EVT_ADAPTER]);
   assign set_evt[chg_pkg::EVT_LIMIT] = arm_ff[chg_pkg::ARM_DEPTH-1] &
      (now_lvl[chg_pkg::EVT_LIMIT] ^ prev_ff[chg_pkg::EVT_LIMIT]);
   assign set_evt[chg_pkg::EVT_COMPLETE] = arm_ff[chg_pkg::ARM_DEPTH-1] &
      now_lvl[chg_pkg::EVT_COMPLETE] & ~prev_ff[chg_pkg::EVT_COMPLETE];

   // Each flag sets on its event and clears on a written one; set wins.
   genvar i;
   generate
      for (i = 0; i < chg_pkg::EVT_N; i++)
      begin : g_flag
         assign nxt_flags[i] = set_evt[i] |
            (flags_ff[i] & ~(ev.clr & ev.wdata[i]));
      end
   endgenerate

   // Upper bits are plain storage, written by any write to the register.
   assign nxt_flags[7:chg_pkg::EVT_N] = ev.clr ?
      ev.wdata[7:chg_pkg::EVT_N] : flags_ff[7:chg_pkg::EVT_N];

   // Request is any enabled flag that stands.
   assign nxt_irq = |(nxt_flags[chg_pkg::EVT_N-1:0] & ev.enables);

   // Flag, history and request registers.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_ff <= '0;
         arm_ff <= '0;
         flags_ff <= chg_pkg::RST_EVF;
         irq_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= now_lvl;
         arm_ff <= {arm_ff[chg_pkg::ARM_DEPTH-2:0], 1'b1};
         flags_ff <= nxt_flags;
         irq_ff <= nxt_irq;
      end
   end

   assign ev.flags = flags_ff;
   assign ev.irq = irq_ff;
endmodule : chg_event_flags

// ==== core/chg_decode.sv ====
`timescale 1ns/100ps
module chg_decode (
   input wire logic clk, // System clock.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic [2:0] rec_code, // Recovery current code.
   input wire logic [1:0] good_code, // Battery good threshold code.
   input wire logic charger_off, // Charger disabled.
   input wire logic charge_priority, // One gives charging the priority.
   input wire logic rail_low, // System rail below the instant-on level.
   output logic [7:0] recovery_ma, // Recovery current in mA.
   output logic [11:0] good_mv, // Battery good threshold in mV.
   output logic charge_stop, // Charging must stop.
   output logic charge_reduce // Charge current must be reduced.
);
   logic [2:0] rec_eff;
   logic [7:0] nxt_rec_ma;
   logic [11:0] nxt_good_mv;
   logic nxt_stop;
   logic nxt_reduce;
   logic [7:0] rec_ma_ff;
   logic [11:0] good_mv_ff;
   logic stop_ff;
   logic reduce_ff;

   // Codes zero and one both give one step of recovery current.
   assign rec_eff = (rec_code == 3'h0) ? 3'h1 : rec_code;
   assign nxt_rec_ma = 8'(rec_eff) * chg_pkg::REC_STEP_MA;
   assign nxt_good_mv = chg_pkg::GOOD_BASE_MV +
      12'(good_code) * chg_pkg::GOOD_STEP_MV;

   // Low rail stops charging unless charging has priority.
   assign nxt_stop = charger_off | (rail_low & ~charge_priority);
   assign nxt_reduce = ~charger_off & rail_low & charge_priority;

   // Registered outputs.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rec_ma_ff <= '0;
         good_mv_ff <= '0;
         stop_ff <= 1'b0;
         reduce_ff <= 1'b0;
      end
      else
      begin
         rec_ma_ff <= nxt_rec_ma;
         good_mv_ff <= nxt_good_mv;
         stop_ff <= nxt_stop;
         reduce_ff <= nxt_reduce;
      end
   end

   assign recovery_ma = rec_ma_ff;
   assign good_mv = good_mv_ff;
   assign charge_stop = stop_ff;
   assign charge_reduce = reduce_ff;
endmodule : chg_decode

// ==== core/chg_regs.sv ====
`timescale 1ns/100ps
module chg_regs (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic nrst, // Asynchronous reset, active low.
   input wire logic [15:0] reg_addr, // Register address.
   input wire logic reg_wr, // Write strobe, one cycle.
   input wire logic reg_rd, // Read strobe, one cycle.
   input wire logic [7:0] reg_wdata, // Write data.
   output logic [7:0] reg_rdata, // Read data, valid after a read.
   input wire logic adapter_in, // Adapter present.
   input wire logic batt_cold_in, // Battery too cold.
   input wire logic batt_hot_in, // Battery too hot.
   input wire logic [1:0] charger_phase, // Charger phase.
   input wire logic batt_fault_in, // Battery cannot be recovered.
   input wire logic timer_terminated, // Cycle ended by the timer.
   input wire logic input_limited, // Input current limiting active.
   input wire logic antiswell_discharging, // Antiswell discharge running.
   input wire logic thermistor_shorted, // Thermistor input shorted.
   input wire logic charging_active, // Charging in progress.
   input wire logic charge_complete, // Charge complete.
   input wire logic system_rail_low, // System rail below instant-on.
   input wire logic die_overtemp, // Die temperature too high.
   output logic charger_off, // Charger disabled.
   output logic recharge_off, // Automatic recharge disabled.
   output logic thermistor_func_off, // Thermistor function disabled.
   output logic voltage_loop_off, // Constant-voltage loop disabled.
   output logic current_loop_off, // Constant-current loop disabled.
   output logic [7:0] recovery_current_ma, // Recovery current in mA.
   output logic [11:0] battery_good_threshold, // Threshold in mV.
   output logic charge_stop, // Charging must stop.
   output logic charge_reduce, // Charge current must be reduced.
   output logic irq // Interrupt request, active high.
);
   logic [chg_pkg::ST_WIDTH-1:0] st_raw;
   logic [chg_pkg::ST_WIDTH-1:0] st_meta_ff;
   logic [chg_pkg::ST_WIDTH-1:0] st_sync_ff;
   logic [7:0] app_ff;
   logic [7:0] spc_ff;
   logic [7:0] eve_ff;
   logic [7:0] rdata_ff;
   logic [7:0] status_one;
   logic [7:0] status_two;
   logic [7:0] rd_mux;
   logic hit_app;
   logic hit_spc;
   logic hit_st1;
   logic hit_st2;
   logic hit_evf;
   logic hit_eve;
   logic wr_app;
   logic wr_spc;
   logic wr_evf;
   logic wr_eve;
   logic [7:0] nxt_app;
   logic [7:0] nxt_spc;
   logic [7:0] nxt_eve;
   logic [7:0] nxt_rdata;

   chg_evt_if ev ();

   // Gather the status pins in register order before synchronising.
   assign st_raw[0] = adapter_in;
   assign st_raw[1] = batt_cold_in;
   assign st_raw[2] = batt_hot_in;
   assign st_raw[4:3] = charger_phase;
   assign st_raw[5] = batt_fault_in;
   assign st_raw[6] = timer_terminated;
   assign st_raw[7] = input_limited;
   assign st_raw[8] = antiswell_discharging;
   assign st_raw[9] = thermistor_shorted;
   assign st_raw[11:10] = 2'h0;
   assign st_raw[12] = charging_active;
   assign st_raw[13] = charge_complete;
   assign st_raw[14] = system_rail_low;
   assign st_raw[15] = die_overtemp;

   // Two-stage synchroniser per status pin; only stage two is read.
   genvar s;
   generate
      for (s = 0; s < chg_pkg::ST_WIDTH; s++)
      begin : g_sync
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               st_meta_ff[s] <= 1'b0;
               st_sync_ff[s] <= 1'b0;
            end
            else
            begin
               st_meta_ff[s] <= st_raw[s];
               st_sync_ff[s] <= st_meta_ff[s];
            end
         end
      end
   endgenerate

   // Read-only status views; reserved bits of status two forced to zero.
   assign status_one = st_sync_ff[7:0];
   assign status_two = st_sync_ff[15:8] & ~chg_pkg::ST2_RSV_MASK;

   // Address decode.
   assign hit_app = (reg_addr == chg_pkg::ADDR_APP);
   assign hit_spc = (reg_addr == chg_pkg::ADDR_SPC);
   assign hit_st1 = (reg_addr == chg_pkg::ADDR_ST1);
   assign hit_st2 = (reg_addr == chg_pkg::ADDR_ST2);
   assign hit_evf = (reg_addr == chg_pkg::ADDR_EVF);
   assign hit_eve = (reg_addr == chg_pkg::ADDR_EVE);

   // Write strobes; the reserved range and status registers ignore writes.
   assign wr_app = reg_wr & hit_app;
   assign wr_spc = reg_wr & hit_spc;
   assign wr_evf = reg_wr & hit_evf;
   assign wr_eve = reg_wr & hit_eve;

   // Next values of the writable registers.
   assign nxt_app = wr_app ? reg_wdata : app_ff;
   assign nxt_spc = wr_spc ? reg_wdata : spc_ff;
   assign nxt_eve = wr_eve ? reg_wdata : eve_ff;

   // Read selection; unmapped addresses read zero.
   assign rd_mux = hit_app ? app_ff :
                   hit_spc ? spc_ff :
                   hit_st1 ? status_one :
                   hit_st2 ? status_two :
                   hit_evf ? ev.flags :
                   hit_eve ? eve_ff : 8'h00;
   assign nxt_rdata = reg_rd ? rd_mux : rdata_ff;

   // Control registers and read data holding register.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         app_ff <= chg_pkg::RST_APP;
         spc_ff <= chg_pkg::RST_SPC;
         eve_ff <= chg_pkg::RST_EVE;
         rdata_ff <= 8'h00;
      end
      else
      begin
         app_ff <= nxt_app;
         spc_ff <= nxt_spc;
         eve_ff <= nxt_eve;
         rdata_ff <= nxt_rdata;
      end
   end

   // Event flag block fed from synchronised status and the flag write.
   assign ev.adapter = st_sync_ff[chg_pkg::ST_ADAPTER];
   assign ev.limited = st_sync_ff[chg_pkg::ST_LIMITED];
   assign ev.complete = st_sync_ff[chg_pkg::ST_COMPLETE];
   assign ev.clr = wr_evf;
   assign ev.wdata = reg_wdata;
   assign ev.enables = eve_ff[chg_pkg::EVT_N-1:0];

   chg_event_flags u_flags (
      .clk (clk),
      .nrst (nrst),
      .ev (ev.evt)
   );

   // Decoders for the application settings and the rail priority.
   chg_decode u_decode (
      .clk (clk),
      .nrst (nrst),
      .rec_code (app_ff[chg_pkg::APP_REC_MSB:chg_pkg::APP_REC_LSB]),
      .good_code (app_ff[chg_pkg::APP_GOOD_MSB:chg_pkg::APP_GOOD_LSB]),
      .charger_off (spc_ff[chg_pkg::SPC_CHARGER_OFF]),
      .charge_priority (spc_ff[chg_pkg::SPC_PRIORITY]),
      .rail_low (st_sync_ff[chg_pkg::ST_RAIL_LOW]),
      .recovery_ma (recovery_current_ma),
      .good_mv (battery_good_threshold),
      .charge_stop (charge_stop),
      .charge_reduce (charge_reduce)
   );

   // Disable controls come straight from the special control register.
   assign charger_off = spc_ff[chg_pkg::SPC_CHARGER_OFF];
   assign recharge_off = spc_ff[chg_pkg::SPC_RECHARGE_OFF];
   assign thermistor_func_off = spc_ff[chg_pkg::SPC_THERM_OFF];
   assign voltage_loop_off = spc_ff[chg_pkg::SPC_VLOOP_OFF];
   assign current_loop_off = spc_ff[chg_pkg::SPC_CLOOP_OFF];
   assign reg_rdata = rdata_ff;
   assign irq = ev.irq;
endmodule : chg_regs

// ==== testbench/chg_regs_sva.sv ====
`timescale 1ns/100ps
// Watches the register port and the decoded outputs of the bank.
module chg_regs_sva (
   input wire logic clk, // Clock.
   input wire logic nrst, // Reset, active low.
   input wire logic [15:0] reg_addr, // Address.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic [7:0] reg_rdata, // Read data.
   input wire logic charger_off, // Charger off.
   input wire logic [7:0] recovery_current_ma, // Recovery current.
   input wire logic [11:0] battery_good_threshold, // Threshold.
   input wire logic charge_stop, // Stop charging.
   input wire logic charge_reduce, // Reduce charging.
   input wire logic irq // Interrupt request.
);
   // Expected decodes of the write data and the access classes.
   wire logic [2:0] rec_code = reg_wdata[7:5];
   wire logic [7:0] rec_exp = (rec_code < 3'h2) ? chg_pkg::REC_STEP_MA :
      8'(rec_code) * chg_pkg::REC_STEP_MA;
   wire logic [11:0] good_exp = chg_pkg::GOOD_BASE_MV +
      12'(reg_wdata[4:3]) * chg_pkg::GOOD_STEP_MV;
   wire logic app_wr = reg_wr && reg_addr == chg_pkg::ADDR_APP;
   // A flag clear drops the request at its own edge, while an enable write
   // takes one more edge, because the request is built from the old enables.
   wire logic evf_wr = reg_wr && reg_addr == chg_pkg::ADDR_EVF;
   wire logic eve_wr = reg_wr && reg_addr == chg_pkg::ADDR_EVE;
   wire logic unmapped = reg_addr < chg_pkg::ADDR_APP ||
      reg_addr > chg_pkg::ADDR_EVE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_rec_decode: assert property (
      app_wr |-> ##2 recovery_current_ma == $past(rec_exp, 2))
      else $error("Recovery current does not match the code.");
   a_good_decode: assert property (
      app_wr |-> ##2 battery_good_threshold == $past(good_exp, 2))
      else $error("Good threshold does not match the code.");
   a_stop_on_off: assert property (charger_off |=> charge_stop)
      else $error("Charger off without a stop.");
   a_stop_reduce_excl: assert property (
      !(charge_stop && charge_reduce))
      else $error("Stop and reduce together.");
   a_rdata_holds: assert property (
      !$past(reg_rd) |-> $stable(reg_rdata))
      else $error("Read data moved without a read.");
   a_unmapped_zero: assert property (
      reg_rd && unmapped |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero.");
   a_st2_rsv_zero: assert property (
      reg_rd && reg_addr == chg_pkg::ADDR_ST2 |=>
      (reg_rdata & chg_pkg::ST2_RSV_MASK) == 8'h00)
      else $error("Reserved status bits not zero.");
   a_irq_fall_cause: assert property (
      $fell(irq) |-> $past(evf_wr) || $past(eve_wr, 2))
      else $error("Request dropped without a flag or enable write.");
endmodule : chg_regs_sva

// ==== testbench/chg_host_model.sv ====
`timescale 1ns/100ps
// Host on the register port: one access at a time, address and data
// inverted while idle so that nothing stale looks valid.
module chg_host_model (
   input wire logic clk, // System clock.
   output logic [15:0] reg_addr, // Register address.
   output logic reg_wr, // Write strobe.
   output logic reg_rd, // Read strobe.
   output logic [7:0] reg_wdata, // Write data.
   input wire logic [7:0] reg_rdata // Read data.
);
   // Idle bus at time zero.
   initial
   begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // Writes one register; the reserved range is never written.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      if (a >= chg_pkg::ADDR_RSV_LO && a <= chg_pkg::ADDR_RSV_HI)
         return;
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // Reads one register; data is registered at the strobe edge.
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : chg_host_model

// ==== testbench/tb_chg_regs.sv ====
`timescale 1ns/100ps
// Bench for the charger register bank, driven through the host model.
module tb_chg_regs;
   logic clk = 1'b0;
   logic nrst, reg_wr, reg_rd, irq, charge_stop, charge_reduce;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, recovery_current_ma;
   logic [11:0] battery_good_threshold;
   logic [1:0] charger_phase;
   logic adapter_in, batt_cold_in, batt_hot_in, batt_fault_in;
   logic timer_terminated, input_limited, antiswell_discharging;
   logic thermistor_shorted, charging_active, charge_complete;
   logic system_rail_low, die_overtemp, charger_off, recharge_off;
   logic thermistor_func_off, voltage_loop_off, current_loop_off;
   int num_errors = 0;
   int samples_checked = 0;
   logic [7:0] pat1 [4] = '{8'ha5, 8'h5a, 8'h0c, 8'h13};
   logic [7:0] pat2 [4] = '{8'hff, 8'h21, 8'h12, 8'hc0};

   // Clock of 100 MHz.
   always #5 clk = ~clk;

   chg_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   chg_regs dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .adapter_in(adapter_in),
      .batt_cold_in(batt_cold_in), .batt_hot_in(batt_hot_in),
      .charger_phase(charger_phase), .batt_fault_in(batt_fault_in),
      .timer_terminated(timer_terminated), .input_limited(input_limited),
      .antiswell_discharging(antiswell_discharging),
      .thermistor_shorted(thermistor_shorted),
      .charging_active(charging_active), .charge_complete(charge_complete),
      .system_rail_low(system_rail_low), .die_overtemp(die_overtemp),
      .charger_off(charger_off), .recharge_off(recharge_off),
      .thermistor_func_off(thermistor_func_off),
      .voltage_loop_off(voltage_loop_off),
      .current_loop_off(current_loop_off),
      .recovery_current_ma(recovery_current_ma),
      .battery_good_threshold(battery_good_threshold),
      .charge_stop(charge_stop), .charge_reduce(charge_reduce), .irq(irq));

   // Compares one value and counts the result.
   task automatic chk_val(input string nm, input logic [11:0] e, g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_val

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic rchk(input string nm, input logic [15:0] a,
      input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(a, d);
      chk_val(nm, {4'h0, e}, {4'h0, d});
   endtask : rchk

   // Drives the status pins from the two status register images.
   task automatic set_st(input logic [7:0] s1, s2);
      {input_limited, timer_terminated, batt_fault_in} = s1[7:5];
      {charger_phase, batt_hot_in, batt_cold_in, adapter_in} = s1[4:0];
      {die_overtemp, system_rail_low, charge_complete} = s2[7:5];
      charging_active = s2[4];
      {thermistor_shorted, antiswell_discharging} = s2[1:0];
   endtask : set_st

   // Waits a bounded time for the request level; a miss ends the run.
   task automatic wait_irq(input logic e);
      for (int i = 0; i < 12 && irq !== e; i++)
         cyc(1);
      chk_val("irq", {11'h0, e}, {11'h0, irq});
      if (irq !== e)
         tally_and_finish();
   endtask : wait_irq

   task automatic chk_defaults;
      rchk("app", chg_pkg::ADDR_APP, 8'h78);
      rchk("spc", chg_pkg::ADDR_SPC, 8'h00);
      rchk("evf", chg_pkg::ADDR_EVF, 8'h00);
      rchk("eve", chg_pkg::ADDR_EVE, 8'h01);
   endtask : chk_defaults

   task automatic tally_and_finish;
      $display("Comparisons %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // Reset, then the scenarios as register accesses and pin changes.
   initial
   begin
      nrst = 1'b0;
      set_st(8'h00, 8'h00);
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      cyc(1);
      chk_val("rec", 12'h04b, {4'h0, recovery_current_ma});
      chk_val("good", 12'haf0, battery_good_threshold);
      chk_defaults();
      for (int c = 0; c < 8; c++)
      begin
         host_u.wr(chg_pkg::ADDR_APP, {3'(c), 2'(c), 3'h0});
         cyc(1);
         chk_val("rec", 12'((c < 2) ? 25 : c * 25),
            {4'h0, recovery_current_ma});
         chk_val("good", 12'(2500 + (c % 4) * 100),
            battery_good_threshold);
      end
      for (int b = 0; b < 5; b++)
      begin
         host_u.wr(chg_pkg::ADDR_SPC, 8'(1 << b));
         cyc(1);
         chk_val("offs", 12'(1 << b), {7'h0, current_loop_off,
            voltage_loop_off, thermistor_func_off, recharge_off, charger_off});
         chk_val("stp", (b == 0) ? 12'h2 : 12'h0,
            {10'h0, charge_stop, charge_reduce});
      end
      set_st(8'h00, 8'h40);
      host_u.wr(chg_pkg::ADDR_SPC, 8'h00);
      cyc(2);
      chk_val("stp", 12'h2, {10'h0, charge_stop, charge_reduce});
      host_u.wr(chg_pkg::ADDR_SPC, 8'h20);
      cyc(1);
      chk_val("stp", 12'h1, {10'h0, charge_stop, charge_reduce});
      for (int i = 0; i < 4; i++)
      begin
         set_st(pat1[i], pat2[i]);
         cyc(4);
         rchk("st1", chg_pkg::ADDR_ST1, pat1[i]);
         rchk("st2", chg_pkg::ADDR_ST2, pat2[i] & 8'hf3);
      end
      host_u.wr(chg_pkg::ADDR_ST1, 8'hff);
      rchk("st1", chg_pkg::ADDR_ST1, 8'h13);
      rchk("hole", 16'ha09c, 8'h00);
      set_st(8'h00, 8'h00);
      host_u.wr(chg_pkg::ADDR_EVE, 8'h00);
      cyc(6);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h07);
      rchk("evf", chg_pkg::ADDR_EVF, 8'h00);
      wait_irq(1'b0);
      host_u.wr(chg_pkg::ADDR_EVE, 8'h01);
      set_st(8'h01, 8'h00);
      wait_irq(1'b1);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h01);
      wait_irq(1'b0);
      set_st(8'h00, 8'h00);
      wait_irq(1'b1);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h01);
      set_st(8'h80, 8'h00);
      cyc(6);
      chk_val("irq", 12'h0, {11'h0, irq});
      rchk("evf", chg_pkg::ADDR_EVF, 8'h02);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h02);
      host_u.wr(chg_pkg::ADDR_EVE, 8'h02);
      set_st(8'h00, 8'h00);
      wait_irq(1'b1);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h02);
      host_u.wr(chg_pkg::ADDR_EVE, 8'h04);
      set_st(8'h00, 8'h20);
      wait_irq(1'b1);
      host_u.wr(chg_pkg::ADDR_EVF, 8'h04);
      set_st(8'h00, 8'h00);
      cyc(6);
      rchk("evf", chg_pkg::ADDR_EVF, 8'h00);
      host_u.wr(chg_pkg::ADDR_EVF, 8'hf8);
      rchk("evf", chg_pkg::ADDR_EVF, 8'hf8);
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(1);
      chk_defaults();
      tally_and_finish();
   end
endmodule : tb_chg_regs

bind chg_regs chg_regs_sva chk_u (.clk(clk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .charger_off(charger_off),
   .recovery_current_ma(recovery_current_ma),
   .battery_good_threshold(battery_good_threshold),
   .charge_stop(charge_stop), .charge_reduce(charge_reduce), .irq(irq));
